// ==== rtl/fbr_pkg.sv ====
package fbr_pkg;

	localparam int ADDR_W   = 24;
	localparam int DATA_W   = 16;
	localparam int CMD_W    = 3;
	localparam int LINE_W   = 7;
	localparam int APB_AW   = 8;

	localparam logic [ADDR_W-1:0] ADDR_STEP  = 24'h000001;
	localparam logic [DATA_W-1:0] CFG0_RESET = 16'hEFC8;
	localparam logic [DATA_W-1:0] CFG1_RESET = 16'hFFEF;
	// arbitrary fill pattern of the modelled array
	localparam logic [DATA_W-1:0] ARRAY_SEED = 16'hA5C3;

	localparam int READ_MODE_BIT = 15;
	localparam int WS_LO_MSB     = 13;
	localparam int WS_LO_LSB     = 11;
	localparam int POLARITY_BIT  = 10;
	localparam int TIMING_BIT    = 8;
	localparam int WRAP_BIT      = 3;
	localparam int BLEN_MSB      = 2;
	localparam int WS_HI_BIT     = 0;

	localparam logic [2:0] BLEN_CONT = 3'h0;
	localparam logic [2:0] BLEN_8    = 3'h2;
	localparam logic [2:0] BLEN_16   = 3'h3;
	localparam logic [2:0] BLEN_32   = 3'h4;
	localparam logic [3:0] WS_DIRECT = 4'h5;
	localparam logic [3:0] WS_OFFSET = 4'h2;
	localparam logic [3:0] BOUNDARY_WS = 4'h1;

	localparam logic [CMD_W-1:0] CMD_SW_RESET = 3'h0;
	localparam logic [CMD_W-1:0] CMD_WR_CFG0  = 3'h1;
	localparam logic [CMD_W-1:0] CMD_WR_CFG1  = 3'h2;
	localparam logic [CMD_W-1:0] CMD_RD_CFG0  = 3'h3;
	localparam logic [CMD_W-1:0] CMD_RD_CFG1  = 3'h4;

	localparam logic [APB_AW-1:0] REG_CTRL   = 8'h00;
	localparam logic [APB_AW-1:0] REG_ADDR   = 8'h04;
	localparam logic [APB_AW-1:0] REG_WDATA  = 8'h08;
	localparam logic [APB_AW-1:0] REG_STATUS = 8'h0C;
	localparam logic [APB_AW-1:0] REG_RDATA  = 8'h10;
	localparam logic [APB_AW-1:0] REG_SHADOW = 8'h14;

	localparam logic [2:0] OP_NONE      = 3'h0;
	localparam logic [2:0] OP_WRITE_CFG = 3'h1;
	localparam logic [2:0] OP_READ_CFG0 = 3'h2;
	localparam logic [2:0] OP_READ_CFG1 = 3'h3;
	localparam logic [2:0] OP_BURST     = 3'h4;
	localparam logic [2:0] OP_WRITE_CFG1 = 3'h5;

	// rising edges from address latch to first data
	function automatic logic [3:0] fbr_latency(input logic [3:0] code);
		if (code <= WS_DIRECT)
			return code + WS_OFFSET;
		return code;
	endfunction

	// words per linear burst, zero means continuous
	function automatic logic [5:0] fbr_burst_words(input logic [2:0] code);
		case (code)
			BLEN_8:  return 6'h08;
			BLEN_16: return 6'h10;
			BLEN_32: return 6'h20;
			default: return 6'h00;
		endcase
	endfunction

endpackage

// ==== rtl/fbr_link_if.sv ====
`timescale 1ns/10ps
interface fbr_link_if (
	input wire logic clock,
	input wire logic rst_n
);
	import fbr_pkg::*;

	logic [ADDR_W-1:0] addressBus;
	logic              address_valid_strobe_n;
	logic              chipEnableN;
	logic              writeStrobeN;
	logic [DATA_W-1:0] writeData;
	logic [DATA_W-1:0] readData;
	logic              readyPin;

	modport device (
		input  clock,
		input  rst_n,
		input  addressBus,
		input  address_valid_strobe_n,
		input  chipEnableN,
		input  writeStrobeN,
		input  writeData,
		output readData,
		output readyPin
	);

	modport host (
		input  clock,
		input  rst_n,
		output addressBus,
		output address_valid_strobe_n,
		output chipEnableN,
		output writeStrobeN,
		output writeData,
		input  readData,
		input  readyPin
	);
endinterface

// ==== rtl/fbr_flash_dev.sv ====
// Functional notes
// - linear burst outputs 8, 16 or 32 words
// - groups aligned to burst length
// - wrap returns to group start, stops after group
// - wrapped burst never adds boundary wait
// - no wrap: count incrementing words, then stop
// - host strobes new address after burst
// - unwrapped crossing of 128 line waits
// - reset gives async mode and defaults
// - host sets configuration before bursts
// - two 16-bit words, readable and writable
// - bit 15 selects sync or async read
// - wait code sets first data edge
// - bit 10 sets ready polarity
// - bit 8 sets ready early or with data
// - bit 3 enables linear wrap
// - continuous mode ignores wrap bit
// - bits 2..0 pick burst length
// - reserved bits reset to fixed values
// - configuration access needs software reset after
// - first word before second, else unchanged
// - continuous burst wraps at top, ends on abort
// - continuous line crossing adds latency
`timescale 1ns/10ps
module fbr_flash_dev
	import fbr_pkg::*;
(
	fbr_link_if.device        link,
	output logic [DATA_W-1:0] cfgPrimary,
	output logic [DATA_W-1:0] cfgSecondary,
	output logic              configAccessLock,
	output logic              burstActive
);

	logic [DATA_W-1:0] read_config_primary_r;
	logic [DATA_W-1:0] read_config_primary_nxt;
	logic [DATA_W-1:0] read_config_secondary_r;
	logic [DATA_W-1:0] read_config_secondary_nxt;
	logic [DATA_W-1:0] stage_r;
	logic [DATA_W-1:0] stage_nxt;
	logic              stageValid_r;
	logic              stageValid_nxt;
	logic              cfgLock_r;
	logic              cfgLock_nxt;
	logic              rdSel_r;
	logic              rdSel_nxt;

	logic              active_r;
	logic              active_nxt;
	logic [3:0]        cnt_r;
	logic [3:0]        cnt_nxt;
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] addr_nxt;
	logic [5:0]        left_r;
	logic [5:0]        left_nxt;
	logic              cont_r;
	logic              cont_nxt;
	logic              wrap_r;
	logic              wrap_nxt;
	logic [DATA_W-1:0] readData_r;
	logic [DATA_W-1:0] readData_nxt;
	logic              readyPin_r;
	logic              loadNow;

	function automatic logic [DATA_W-1:0] array_word(input logic [ADDR_W-1:0] a);
		return a[DATA_W-1:0] ^ ARRAY_SEED;
	endfunction

	// command and latch decode
	wire               cmdWrite  = !link.chipEnableN && !link.writeStrobeN;
	wire [CMD_W-1:0]   cmdSel    = link.addressBus[CMD_W-1:0];
	wire               latch     = !link.chipEnableN && !link.address_valid_strobe_n
	                               && link.writeStrobeN;

	// configuration fields
	wire               syncMode  = !read_config_primary_r[READ_MODE_BIT];
	wire [3:0]         wsCode    = {read_config_secondary_r[WS_HI_BIT],
	                                read_config_primary_r[WS_LO_MSB:WS_LO_LSB]};
	wire [3:0]         latency   = fbr_latency(wsCode);
	wire               polHigh   = read_config_primary_r[POLARITY_BIT];
	wire               withData  = read_config_primary_r[TIMING_BIT];
	wire [5:0]         words     = fbr_burst_words(read_config_primary_r[BLEN_MSB:0]);
	wire               contMode  = (words == 6'h00);
	wire               wrapOn    = read_config_primary_r[WRAP_BIT] && !contMode;

	// burst address sequencing
	wire [ADDR_W-1:0]  groupMask = {{(ADDR_W-6){1'b0}}, words - 6'h01};
	wire [ADDR_W-1:0]  addrInc   = addr_r + ADDR_STEP;
	wire [ADDR_W-1:0]  addrWrap  = (addr_r & ~groupMask) | (addrInc & groupMask);
	wire [ADDR_W-1:0]  nextAddr  = wrap_r ? addrWrap : addrInc;
	wire               crossLine = !wrap_r && (nextAddr[LINE_W-1:0] == '0);
	wire               lastWord  = !cont_r && (left_r == 6'h01);
	wire               seqLoad   = active_r && (cnt_r == 4'h0);
	wire               syncArray = syncMode && !cfgLock_r;
	wire               quickLoad = latch && !syncArray;
	wire [DATA_W-1:0]  cfgWord   = rdSel_r ? read_config_secondary_r : read_config_primary_r;
	wire [DATA_W-1:0]  quickData = cfgLock_r ? cfgWord : array_word(link.addressBus);
	wire               earlyAct  = (active_nxt && (cnt_nxt == 4'h0)) || quickLoad;
	wire               readyAct  = withData ? loadNow : earlyAct;

	always_comb begin
		read_config_primary_nxt   = read_config_primary_r;
		read_config_secondary_nxt = read_config_secondary_r;
		stage_nxt                 = stage_r;
		stageValid_nxt            = stageValid_r;
		cfgLock_nxt               = cfgLock_r;
		rdSel_nxt                 = rdSel_r;
		if (cmdWrite) begin
			case (cmdSel)
				CMD_WR_CFG0: begin
					stage_nxt      = link.writeData;
					stageValid_nxt = 1'b1;
					cfgLock_nxt    = 1'b1;
				end
				CMD_WR_CFG1: begin
					if (stageValid_r) begin
						read_config_primary_nxt   = stage_r;
						read_config_secondary_nxt = link.writeData;
					end
					stageValid_nxt = 1'b0;
					cfgLock_nxt    = 1'b1;
				end
				CMD_RD_CFG0: begin
					rdSel_nxt   = 1'b0;
					cfgLock_nxt = 1'b1;
				end
				CMD_RD_CFG1: begin
					rdSel_nxt   = 1'b1;
					cfgLock_nxt = 1'b1;
				end
				CMD_SW_RESET: begin
					cfgLock_nxt = 1'b0;
				end
				default: begin
					cfgLock_nxt = cfgLock_r;
				end
			endcase
		end
	end

	always_comb begin
		active_nxt   = active_r;
		cnt_nxt      = cnt_r;
		addr_nxt     = addr_r;
		left_nxt     = left_r;
		cont_nxt     = cont_r;
		wrap_nxt     = wrap_r;
		readData_nxt = readData_r;
		loadNow      = 1'b0;
		if (link.chipEnableN) begin
			active_nxt = 1'b0;
		end else if (latch) begin
			// a new strobe aborts any burst in progress
			active_nxt = syncArray;
			cnt_nxt    = latency - WS_OFFSET;
			addr_nxt   = link.addressBus;
			left_nxt   = words;
			cont_nxt   = contMode;
			wrap_nxt   = wrapOn;
			if (!syncArray) begin
				readData_nxt = quickData;
				loadNow      = 1'b1;
			end
		end else if (seqLoad) begin
			readData_nxt = array_word(addr_r);
			loadNow      = 1'b1;
			addr_nxt     = nextAddr;
			left_nxt     = left_r - 6'h01;
			if (lastWord)
				active_nxt = 1'b0;
			else if (crossLine)
				cnt_nxt = BOUNDARY_WS;
		end else if (active_r) begin
			cnt_nxt = cnt_r - 4'h1;
		end
	end

	always_ff @(posedge link.clock or negedge link.rst_n) begin
		if (!link.rst_n) begin
			read_config_primary_r   <= CFG0_RESET;
			read_config_secondary_r <= CFG1_RESET;
			stage_r                 <= CFG0_RESET;
			stageValid_r            <= 1'b0;
			cfgLock_r               <= 1'b0;
			rdSel_r                 <= 1'b0;
		end else begin
			read_config_primary_r   <= read_config_primary_nxt;
			read_config_secondary_r <= read_config_secondary_nxt;
			stage_r                 <= stage_nxt;
			stageValid_r            <= stageValid_nxt;
			cfgLock_r               <= cfgLock_nxt;
			rdSel_r                 <= rdSel_nxt;
		end
	end

	always_ff @(posedge link.clock or negedge link.rst_n) begin
		if (!link.rst_n) begin
			active_r   <= 1'b0;
			cnt_r      <= 4'h0;
			addr_r     <= '0;
			left_r     <= 6'h00;
			cont_r     <= 1'b0;
			wrap_r     <= 1'b0;
			readData_r <= '0;
		end else begin
			active_r   <= active_nxt;
			cnt_r      <= cnt_nxt;
			addr_r     <= addr_nxt;
			left_r     <= left_nxt;
			cont_r     <= cont_nxt;
			wrap_r     <= wrap_nxt;
			readData_r <= readData_nxt;
		end
	end

	// ready pin idles at its inactive level under reset default polarity
	always_ff @(posedge link.clock or negedge link.rst_n) begin
		if (!link.rst_n)
			readyPin_r <= 1'b0;
		else
			readyPin_r <= polHigh ? readyAct : !readyAct;
	end

	assign link.readData    = readData_r;
	assign link.readyPin    = readyPin_r;
	assign cfgPrimary       = read_config_primary_r;
	assign cfgSecondary     = read_config_secondary_r;
	assign configAccessLock = cfgLock_r;
	assign burstActive      = active_r;

endmodule // fbr_flash_dev

// ==== rtl/fbr_flash_host.sv ====
`timescale 1ns/10ps
module fbr_flash_host
	import fbr_pkg::*;
(
	fbr_link_if.host          link,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr
);

	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_CMD   = 3'b001,
		H_LATCH = 3'b010,
		H_WAIT  = 3'b011,
		H_END   = 3'b100
	} fbr_hstate_type;

	fbr_hstate_type    state_r;
	fbr_hstate_type    state_nxt;
	logic [1:0]        step_r;
	logic [1:0]        step_nxt;
	logic [2:0]        op_r;
	logic [7:0]        contCount_r;
	logic [ADDR_W-1:0] addr_r;
	logic [31:0]       wdata_r;
	logic [DATA_W-1:0] rdata_r;
	logic [7:0]        got_r;
	logic [7:0]        want_r;
	logic [DATA_W-1:0] shadow0_r;
	logic [DATA_W-1:0] shadow1_r;
	logic              readyDly_r;
	logic              ceN_r;
	logic              weN_r;
	logic              avdN_r;
	logic [ADDR_W-1:0] pinAddr_r;
	logic [DATA_W-1:0] pinData_r;
	logic [31:0]       prdata_r;
	logic              pready_r;
	logic              pslverr_r;

	function automatic logic [CMD_W-1:0] host_cmd(input logic [2:0] op,
	                                              input logic [1:0] step);
		if (step != 2'h0 && !(op == OP_WRITE_CFG && step == 2'h1))
			return CMD_SW_RESET;
		case (op)
			OP_WRITE_CFG:  return (step == 2'h0) ? CMD_WR_CFG0 : CMD_WR_CFG1;
			OP_WRITE_CFG1: return CMD_WR_CFG1;
			OP_READ_CFG0:  return CMD_RD_CFG0;
			OP_READ_CFG1:  return CMD_RD_CFG1;
			default:       return CMD_SW_RESET;
		endcase
	endfunction

	// APB decode
	wire        setup    = psel && !penable;
	wire        apbWr    = psel && penable && pready_r && pwrite;
	wire        mapped   = (paddr == REG_CTRL) || (paddr == REG_ADDR) || (paddr == REG_WDATA)
	                       || (paddr == REG_STATUS) || (paddr == REG_RDATA)
	                       || (paddr == REG_SHADOW);
	wire        busy     = (state_r != H_IDLE);
	wire [2:0]  opIn     = pwdata[2:0];
	wire        startOp  = apbWr && (paddr == REG_CTRL) && !busy && (opIn != OP_NONE);
	wire [31:0] rdMux    = (paddr == REG_CTRL)   ? {16'h0000, contCount_r, 5'h00, op_r} :
	                       (paddr == REG_ADDR)   ? {8'h00, addr_r} :
	                       (paddr == REG_WDATA)  ? wdata_r :
	                       (paddr == REG_STATUS) ? {16'h0000, got_r, 7'h00, busy} :
	                       (paddr == REG_RDATA)  ? {16'h0000, rdata_r} :
	                       (paddr == REG_SHADOW) ? {shadow1_r, shadow0_r} : 32'h0000_0000;

	// link side decode
	wire [2:0]       opCur    = busy ? op_r : opIn;
	wire [CMD_W-1:0] curCmd   = host_cmd(op_r, step_r);
	wire [CMD_W-1:0] nxtCmd   = host_cmd(opCur, step_nxt);
	wire             isRdCmd  = (curCmd == CMD_RD_CFG0) || (curCmd == CMD_RD_CFG1);
	wire             isRdOp   = (op_r == OP_READ_CFG0) || (op_r == OP_READ_CFG1);
	wire             readyAct = shadow0_r[POLARITY_BIT] ? link.readyPin : !link.readyPin;
	wire             capture  = (state_r == H_WAIT)
	                            && (shadow0_r[TIMING_BIT] ? readyAct : readyDly_r);
	wire [7:0]       gotInc   = got_r + 8'h01;
	wire [5:0]       blWords  = fbr_burst_words(shadow0_r[BLEN_MSB:0]);
	wire [7:0]       contWant = (pwdata[15:8] == 8'h00) ? 8'h01 : pwdata[15:8];
	wire [7:0]       burstWant = shadow0_r[READ_MODE_BIT] ? 8'h01 :
	                             (blWords == 6'h00) ? contWant : {2'b00, blWords};
	wire [7:0]       wantIn   = (opIn == OP_BURST) ? burstWant : 8'h01;
	wire             linkOn   = (state_nxt == H_CMD) || (state_nxt == H_LATCH)
	                            || (state_nxt == H_WAIT);

	always_comb begin
		state_nxt = state_r;
		step_nxt  = step_r;
		case (state_r)
			H_IDLE: begin
				step_nxt = 2'h0;
				if (startOp)
					state_nxt = (opIn == OP_BURST) ? H_LATCH : H_CMD;
			end
			H_CMD: begin
				if (curCmd == CMD_SW_RESET)
					state_nxt = H_END;
				else if (isRdCmd)
					state_nxt = H_LATCH;
				else
					step_nxt = step_r + 2'h1;
			end
			H_LATCH: state_nxt = H_WAIT;
			H_WAIT: begin
				if (capture && (gotInc == want_r)) begin
					state_nxt = isRdOp ? H_CMD : H_END;
					step_nxt  = step_r + 2'h1;
				end
			end
			H_END:   state_nxt = H_IDLE;
			default: state_nxt = H_IDLE;
		endcase
	end

	always_ff @(posedge link.clock or negedge link.rst_n) begin
		if (!link.rst_n) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r  <= setup ? rdMux : prdata_r;
			pready_r  <= setup;
			pslverr_r <= setup && !mapped;
		end
	end

	always_ff @(posedge link.clock or negedge link.rst_n) begin
		if (!link.rst_n) begin
			op_r        <= OP_NONE;
			contCount_r <= 8'h00;
			addr_r      <= '0;
			wdata_r     <= 32'h0000_0000;
		end else if (apbWr && (paddr == REG_ADDR)) begin
			addr_r <= pwdata[ADDR_W-1:0];
		end else if (apbWr && (paddr == REG_WDATA)) begin
			wdata_r <= pwdata;
		end else if (startOp) begin
			op_r        <= opIn;
			contCount_r <= pwdata[15:8];
		end
	end

	always_ff @(posedge link.clock or negedge link.rst_n) begin
		if (!link.rst_n) begin
			state_r    <= H_IDLE;
			step_r     <= 2'h0;
			got_r      <= 8'h00;
			want_r     <= 8'h00;
			rdata_r    <= '0;
			readyDly_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			step_r     <= step_nxt;
			got_r      <= startOp ? 8'h00 : (capture ? gotInc : got_r);
			want_r     <= startOp ? wantIn : want_r;
			rdata_r    <= capture ? link.readData : rdata_r;
			readyDly_r <= (state_r == H_WAIT) && readyAct;
		end
	end

	// host copy of configuration, follows only a committed pair
	always_ff @(posedge link.clock or negedge link.rst_n) begin
		if (!link.rst_n) begin
			shadow0_r <= CFG0_RESET;
			shadow1_r <= CFG1_RESET;
		end else if ((state_r == H_CMD) && (op_r == OP_WRITE_CFG) && (curCmd == CMD_WR_CFG1)) begin
			shadow0_r <= wdata_r[DATA_W-1:0];
			shadow1_r <= wdata_r[31:DATA_W];
		end
	end

	always_ff @(posedge link.clock or negedge link.rst_n) begin
		if (!link.rst_n) begin
			ceN_r     <= 1'b1;
			weN_r     <= 1'b1;
			avdN_r    <= 1'b1;
			pinAddr_r <= '0;
			pinData_r <= '0;
		end else begin
			ceN_r     <= !linkOn;
			weN_r     <= (state_nxt != H_CMD);
			avdN_r    <= (state_nxt != H_LATCH);
			pinAddr_r <= (state_nxt == H_CMD) ? {{(ADDR_W-CMD_W){1'b0}}, nxtCmd} : addr_r;
			pinData_r <= (step_nxt == 2'h0) ? wdata_r[DATA_W-1:0] : wdata_r[31:DATA_W];
		end
	end

	assign link.chipEnableN            = ceN_r;
	assign link.writeStrobeN           = weN_r;
	assign link.address_valid_strobe_n = avdN_r;
	assign link.addressBus             = pinAddr_r;
	assign link.writeData              = pinData_r;
	assign prdata                      = prdata_r;
	assign pready                      = pready_r;
	assign pslverr                     = pslverr_r;

endmodule // fbr_flash_host

// ==== test/fbr_link_checker.sv ====
`timescale 1ns/10ps
module fbr_link_checker
	import fbr_pkg::*;
(
	input wire logic              clock,
	input wire logic              rst_n,
	input wire logic [ADDR_W-1:0] addressBus,
	input wire logic              address_valid_strobe_n,
	input wire logic              chipEnableN,
	input wire logic              writeStrobeN,
	input wire logic [DATA_W-1:0] writeData,
	input wire logic [DATA_W-1:0] readData,
	input wire logic              readyPin
);
	logic [DATA_W-1:0] cfg0_r, cfg1_r, stage_r, rdPrev_r;
	logic              staged_r, lock_r, waiting_r;
	logic [4:0]        waitCnt_r;
	wire               wrCmd    = !chipEnableN && !writeStrobeN;
	wire  [2:0]        sel      = addressBus[2:0];
	wire               latch    = !chipEnableN && !address_valid_strobe_n && writeStrobeN;
	wire               syncMode = !cfg0_r[READ_MODE_BIT] && !lock_r;
	wire  [3:0]        wsCode   = {cfg1_r[WS_HI_BIT], cfg0_r[WS_LO_MSB:WS_LO_LSB]};
	wire  [4:0]        lat      = (wsCode <= 4'h5) ? wsCode + 5'h02 : {1'b0, wsCode};

	// shadow of the committed configuration as seen on the wire
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg0_r   <= CFG0_RESET;
			cfg1_r   <= CFG1_RESET;
			stage_r  <= 16'h0000;
			staged_r <= 1'b0;
			lock_r   <= 1'b0;
		end else if (wrCmd) begin
			lock_r <= (sel != CMD_SW_RESET);
			if (sel == CMD_WR_CFG0) begin
				stage_r  <= writeData;
				staged_r <= 1'b1;
			end
			if (sel == CMD_WR_CFG1 && staged_r) begin
				cfg0_r   <= stage_r;
				cfg1_r   <= writeData;
				staged_r <= 1'b0;
			end
		end
	end

	// edges since address latch, until first word
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			waiting_r <= 1'b0;
			waitCnt_r <= 5'h00;
			rdPrev_r  <= 16'h0000;
		end else begin
			rdPrev_r <= readData;
			if (latch) begin
				waiting_r <= syncMode;
				waitCnt_r <= 5'h01;
			end else if (waiting_r) begin
				waiting_r <= !((readData != rdPrev_r) || chipEnableN);
				waitCnt_r <= waitCnt_r + 5'h01;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence cmdSeq(logic [2:0] s);
		wrCmd && sel == s;
	endsequence
	sequence cfgTail;
		cmdSeq(CMD_WR_CFG1) ##1 cmdSeq(CMD_SW_RESET);
	endsequence

	cfg_write_order_a: assert property (cmdSeq(CMD_WR_CFG0) |=> cfgTail)
		else $error("primary write not followed by secondary and reset");
	reset_after_cfg_a: assert property (cmdSeq(CMD_WR_CFG1) |=> cmdSeq(CMD_SW_RESET))
		else $error("secondary write not followed by software reset");
	async_word_a: assert property (latch && cfg0_r[READ_MODE_BIT] && !lock_r |=>
		readData == ($past(addressBus[15:0]) ^ ARRAY_SEED))
		else $error("asynchronous word wrong");
	first_data_a: assert property (waiting_r && $changed(readData) |-> waitCnt_r == lat)
		else $error("first word at wrong edge");
	ready_with_data_a: assert property (syncMode && cfg0_r[TIMING_BIT] && !chipEnableN
		&& $changed(readData) |-> readyPin == cfg0_r[POLARITY_BIT])
		else $error("ready not active with data");
	ready_early_a: assert property (syncMode && !cfg0_r[TIMING_BIT] && !chipEnableN
		&& $changed(readData) |-> $past(readyPin) == cfg0_r[POLARITY_BIT])
		else $error("ready not active before data");
	strobe_pulse_a: assert property (!address_valid_strobe_n |->
		!chipEnableN && writeStrobeN ##1 address_valid_strobe_n)
		else $error("address strobe malformed");
	ce_idle_a: assert property (chipEnableN && $past(chipEnableN) |-> $stable(readData))
		else $error("data moved while deselected");
endmodule // fbr_link_checker

// ==== test/flash_burst_read_config_bench.sv ====
`timescale 1ns/10ps
module flash_burst_read_config_bench
	import fbr_pkg::*;
();
	logic              clock, rst_n, psel, penable, pwrite, pready, pslverr;
	logic              mon, pol, tim, rdyQ, configAccessLock, burstActive;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata;
	logic [DATA_W-1:0] cfgPrimary, cfgSecondary, got[$];
	logic [15:0]       seed;
	int                n_fail, checked, cyc, at[$];

	fbr_link_if link (.clock(clock), .rst_n(rst_n));
	fbr_flash_dev fbr_flash_dev_inst (.link(link), .cfgPrimary(cfgPrimary),
		.cfgSecondary(cfgSecondary), .configAccessLock(configAccessLock),
		.burstActive(burstActive));
	fbr_flash_host fbr_flash_host_inst (.link(link), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	fbr_link_checker fbr_link_checker_inst (.clock(clock), .rst_n(rst_n),
		.addressBus(link.addressBus), .address_valid_strobe_n(link.address_valid_strobe_n),
		.chipEnableN(link.chipEnableN), .writeStrobeN(link.writeStrobeN),
		.writeData(link.writeData), .readData(link.readData), .readyPin(link.readyPin));

	always #4 clock = ~clock;

	// words taken off the wire with their cycle stamps
	always @(posedge clock) begin
		cyc <= cyc + 1;
		rdyQ <= link.readyPin;
		// only words shown while the host still selects the device
		if (mon && link.chipEnableN === 1'b0 && ((tim ? link.readyPin : rdyQ) === pol)) begin
			got.push_back(link.readData);
			at.push_back(cyc);
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [23:0] expAddr(input logic [23:0] s, input int i, input int w,
		input logic wrap);
		logic [23:0] m;
		m = 24'(w - 1);
		if (w == 0 || !wrap)
			return s + 24'(i);
		return (s & ~m) | ((s + 24'(i)) & m);
	endfunction

	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clock);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic run(input logic [31:0] ctrl);
		logic [31:0] r;
		logic        e;
		int          n;
		wr(REG_CTRL, ctrl);
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h00000000, r, e);
			n++;
		end while (r[0] !== 1'b0 && n < 300);
		if (n >= 300)
			chk16(16'h0000, 16'h0001);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clock);
		n_fail++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		test_done();
	end

	initial begin
		logic [31:0] r;
		logic        e;
		logic [15:0] c0, c1, gap;
		logic [23:0] st, a;
		logic [3:0]  ws;
		logic [2:0]  bl;
		int          w, nw;
		clock = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		mon = 1'b0;
		pol = 1'b1;
		tim = 1'b1;
		seed = 16'h004B;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		chk16(cfgPrimary, CFG0_RESET);
		chk16(cfgSecondary, CFG1_RESET);
		apb(1'b0, REG_SHADOW, 32'h00000000, r, e);
		chk32(r, {CFG1_RESET, CFG0_RESET});
		apb(1'b0, 8'h3C, 32'h00000000, r, e);
		chk32({e, r[30:0]}, 32'h80000000);
		wr(REG_WDATA, 32'h12340000);
		run(32'h00000005);
		chk16(cfgSecondary, CFG1_RESET);
		chk16(cfgPrimary, CFG0_RESET);
		wr(REG_ADDR, {16'h0000, seed});
		run(32'h00000004);
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			ws = seed[3:0] % 4'hA;
			if (ws > 4'h5)
				ws = ws + 4'h2;
			bl = (i[2:1] == 2'h0) ? BLEN_CONT : {1'b0, i[2:1]} + 3'h1;
			w = (bl == BLEN_CONT) ? 0 : (8 << (bl - 3'h2));
			nw = (w == 0) ? 8 : w;
			pol = seed[4];
			tim = seed[5];
			c0 = CFG0_RESET;
			c0[READ_MODE_BIT] = 1'b0;
			c0[WS_LO_MSB:WS_LO_LSB] = ws[2:0];
			c0[POLARITY_BIT] = pol;
			c0[TIMING_BIT] = tim;
			c0[WRAP_BIT] = i[0];
			c0[BLEN_MSB:0] = bl;
			c1 = CFG1_RESET;
			c1[WS_HI_BIT] = ws[3];
			wr(REG_WDATA, {c1, c0});
			run({29'h00000000, OP_WRITE_CFG});
			chk16(cfgPrimary, c0);
			chk16(cfgSecondary, c1);
			chk16({15'h0000, configAccessLock}, 16'h0000);
			st = {seed, seed[7:0]};
			if (i[3])
				st[6:0] = 7'h7C;
			if (i[3] && w == 0)
				st = 24'hFFFFFC;
			wr(REG_ADDR, {8'h00, st});
			got.delete();
			at.delete();
			mon <= 1'b1;
			run({16'h0000, 8'(nw), 5'h00, OP_BURST});
			mon <= 1'b0;
			chk16({15'h0000, burstActive}, 16'h0000);
			chk16(16'(got.size()), 16'(nw));
			for (int k = 0; k < got.size() && k < nw; k++) begin
				a = expAddr(st, k, w, i[0]);
				gap = (a[6:0] == 7'h00 && (w == 0 || !i[0])) ? 16'h0002 : 16'h0001;
				chk16(got[k], a[15:0] ^ ARRAY_SEED);
				if (k > 0)
					chk16(16'(at[k] - at[k - 1]), gap);
			end
			apb(1'b0, REG_STATUS, 32'h00000000, r, e);
			chk16({8'h00, r[15:8]}, 16'(nw));
		end
		run({29'h00000000, OP_READ_CFG0});
		apb(1'b0, REG_RDATA, 32'h00000000, r, e);
		chk16(r[15:0], c0);
		run({29'h00000000, OP_READ_CFG1});
		apb(1'b0, REG_RDATA, 32'h00000000, r, e);
		chk16(r[15:0], c1);
		chk16({15'h0000, configAccessLock}, 16'h0000);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		chk16(cfgPrimary, CFG0_RESET);
		test_done();
	end
endmodule // flash_burst_read_config_bench
